/* hw/mcs_sequencer.sv */
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module mcs_sequencer import mcs_pkg::*; #(
  parameter int MEAS_CYC = CYC_MEAS,
  parameter int SQUELCH_CYC = CYC_SQUELCH,
  parameter int REGADJ_CYC = CYC_REGADJ,
  parameter int REGSTEP_CYC = CYC_REGSTEP,
  parameter int MODCAL_CYC = CYC_MODCAL,
  parameter int ANTCAL_CYC = CYC_ANTCAL,
  parameter int CSCAL_CYC = CYC_CSCAL,
  parameter int CAPMEAS_CYC = CYC_CAPMEAS
) (
  input wire logic ref_clk, // 250 MHz
  input wire logic sys_rst, // Sync reset
  input wire logic clkEn, // Freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // Unmapped address
  input wire logic xtalStable, // Crystal stable
  input wire logic txRunning, // Transmitter operating
  input wire logic rxRunning, // Receiver operating
  input wire logic rxActive, // Receive active
  input wire logic slaveSelPin, // Slave select pin
  input wire logic railMarginOk, // rf rail 250 mV below VDD
  input wire logic adcDone, // ADC conversion done
  input wire logic [7:0] adcData, // ADC code
  input wire logic calDone, // Analog calibration done
  input wire logic [7:0] calResult, // Calibration outcome
  input wire logic squelchDone, // Squelch finished
  input wire logic [3:0] rssiIn, // Instant RSSI
  output logic txEnable, // Transmitter on
  output logic rxEnable, // Receiver on
  output logic ampDetEnable, // Amplitude detector on
  output logic phaseDetEnable, // Phase detector on
  output logic adcRelative, // ADC relative mode
  output logic [1:0] adcMux, // ADC source
  output logic [1:0] supplyProbeSel, // Supply probe select
  output logic adcStart, // Start conversion pulse
  output logic [3:0] regCode, // Regulator step
  output logic modCalStart, // Depth calibration pulse
  output logic [7:0] modTarget, // Depth target
  output logic antCalStart, // Antenna calibration pulse
  output logic [3:0] tuningCapacitorPins, // Tuning caps
  output logic capCalStart, // Capsense calibration pulse
  output logic capMeasStart, // Capacitance meas pulse
  output logic squelchStart, // Squelch start pulse
  output logic agcInit, // AGC/squelch/RSSI init pulse
  output logic [7:0] gainReduction, // Loaded gain reduction
  output logic rssiGate, // RSSI and AGC enable
  output logic transparentMode, // Transparent mode
  output logic chainAllowed, // Last command chains
  output logic cmdDone // Completion pulse
);

  mcs_state_type state_reg;
  mcs_cmd_type cmd_reg;
  logic [7:0] ctrl_reg, modTgt_reg, rxCfg4_reg, adc_reg, modDisp_reg;
  logic [3:0] rssi_reg;
  logic [23:0] totCnt_reg, stepCnt_reg;
  logic doneFlag_reg, transpArm_reg, rxActPrev_reg;
  logic ss1_reg, ss2_reg, ss3_reg, ssLevel_reg;
  logic wrAcc, cmdWr, accept, finish, ssRise;
  mcs_cmd_type newCmd;

  function automatic logic isMeasure(input mcs_cmd_type c);
    case (c)
      CMD_AMP, CMD_PHASE, CMD_SUPPLY, CMD_REGADJ, CMD_MODCAL,
      CMD_ANTCAL, CMD_CSCAL, CMD_CAPMEAS: isMeasure = 1'b1;
      default: isMeasure = 1'b0;
    endcase
  endfunction : isMeasure

  function automatic logic [23:0] cmdLimit(input mcs_cmd_type c);
    case (c)
      CMD_SQUELCH: cmdLimit = 24'(SQUELCH_CYC);
      CMD_REGADJ: cmdLimit = 24'(REGADJ_CYC);
      CMD_MODCAL: cmdLimit = 24'(MODCAL_CYC);
      CMD_ANTCAL: cmdLimit = 24'(ANTCAL_CYC);
      CMD_CSCAL: cmdLimit = 24'(CSCAL_CYC);
      CMD_CAPMEAS: cmdLimit = 24'(CAPMEAS_CYC);
      default: cmdLimit = 24'(MEAS_CYC);
    endcase
  endfunction : cmdLimit

  assign pready = clkEn;
  assign wrAcc = psel & penable & pwrite & clkEn;
  assign cmdWr = wrAcc & (paddr == ADDR_CMD);
  assign newCmd = mcs_cmd_type'(pwdata[3:0]);
  assign modTarget = modTgt_reg;
  assign rssiGate = rxActive;
  assign ssRise = (ss2_reg == ss3_reg) & ss3_reg & ~ssLevel_reg;

  // Acceptance; a refused command leaves every register as it was
  always_comb begin
    logic base;
    base = ctrl_reg[EN_BIT] & xtalStable;
    accept = 1'b0;
    if (cmdWr) begin
      case (newCmd)
        CMD_AMP, CMD_PHASE, CMD_SUPPLY, CMD_MODCAL, CMD_ANTCAL,
        CMD_RSSICLR, CMD_TRANSP: accept = base & (state_reg == ST_IDLE);
        CMD_GAINRST: accept = base & ((state_reg == ST_IDLE) |
                                      (state_reg == ST_SQUELCH));
        CMD_REGADJ: accept = base & ~ctrl_reg[EXTREG_BIT]
                             & (state_reg == ST_IDLE);
        CMD_SQUELCH: accept = txRunning & rxRunning
                              & (state_reg == ST_IDLE);
        CMD_CSCAL: accept = (ctrl_reg[MCAL_LSB +: 4] == 4'h0)
                            & (state_reg == ST_IDLE);
        CMD_CAPMEAS: accept = (state_reg == ST_IDLE);
        default: accept = 1'b0;
      endcase
    end
  end

  // Pin is asynchronous: three stages, level taken when last two agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ss1_reg <= 1'b0;
      ss2_reg <= 1'b0;
      ss3_reg <= 1'b0;
      ssLevel_reg <= 1'b0;
    end else if (clkEn) begin
      ss1_reg <= slaveSelPin;
      ss2_reg <= ss1_reg;
      ss3_reg <= ss2_reg;
      if (ss2_reg == ss3_reg) begin
        ssLevel_reg <= ss3_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      transpArm_reg <= 1'b0;
      transparentMode <= 1'b0;
    end else if (clkEn) begin
      if (accept && newCmd == CMD_TRANSP) begin
        transpArm_reg <= 1'b1;
      end else if (ssRise && transpArm_reg) begin
        transpArm_reg <= 1'b0;
        transparentMode <= 1'b1;
      end else if (!ssLevel_reg) begin
        transparentMode <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      modTgt_reg <= MODTGT_RST;
      rxCfg4_reg <= RXCFG4_RST;
    end else if (wrAcc) begin
      case (paddr)
        ADDR_CTRL: ctrl_reg <= pwdata[7:0];
        ADDR_MODTGT: modTgt_reg <= pwdata[7:0];
        ADDR_RXCFG4: rxCfg4_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      ADDR_CMD: prdata[3:0] = cmd_reg;
      ADDR_CTRL: prdata[7:0] = ctrl_reg;
      ADDR_STAT: begin
        prdata[STAT_BUSY] = (state_reg != ST_IDLE);
        prdata[STAT_DONE] = doneFlag_reg;
        prdata[STAT_CHAIN] = chainAllowed;
        prdata[STAT_TRANSP] = transparentMode;
      end
      ADDR_ADC: prdata[7:0] = adc_reg;
      ADDR_RSSI: prdata[3:0] = rssi_reg;
      ADDR_REGV: prdata[3:0] = regCode;
      ADDR_MODTGT: prdata[7:0] = modTgt_reg;
      ADDR_MODDISP: prdata[7:0] = modDisp_reg;
      ADDR_RXCFG4: prdata[7:0] = rxCfg4_reg;
      default: pslverr = psel & penable;
    endcase
  end

  // Done is sticky; a new completion beats a same-cycle clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      doneFlag_reg <= 1'b0;
    end else if (clkEn) begin
      if (cmdDone) begin
        doneFlag_reg <= 1'b1;
      end else if (wrAcc && paddr == ADDR_STAT && pwdata[STAT_DONE]) begin
        doneFlag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chainAllowed <= 1'b0;
      cmd_reg <= CMD_AMP;
    end else if (clkEn && accept) begin
      cmd_reg <= newCmd;
      chainAllowed <= ~isMeasure(newCmd) & (newCmd != CMD_SQUELCH)
                      & (newCmd != CMD_TRANSP);
    end
  end

  // Peak hold, restarted on receive active rise or clear command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rssi_reg <= 4'h0;
      rxActPrev_reg <= 1'b0;
    end else if (clkEn) begin
      rxActPrev_reg <= rxActive;
      if ((rxActive && !rxActPrev_reg) ||
          (accept && newCmd == CMD_RSSICLR)) begin
        rssi_reg <= 4'h0;
      end else if (rxActive && rssiIn > rssi_reg) begin
        rssi_reg <= rssiIn;
      end
    end
  end

  assign finish = (state_reg == ST_ADC && (adcDone || totCnt_reg == 0))
    || (state_reg == ST_CAL && (calDone || totCnt_reg == 0))
    || (state_reg == ST_SETTLE && (totCnt_reg == 0 ||
        (stepCnt_reg == 0 && (railMarginOk || regCode == REG_MIN))));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      totCnt_reg <= 24'h00_0000;
      stepCnt_reg <= 24'h00_0000;
    end else if (clkEn) begin
      if (totCnt_reg != 0) begin
        totCnt_reg <= totCnt_reg - 24'h00_0001;
      end
      if (stepCnt_reg != 0) begin
        stepCnt_reg <= stepCnt_reg - 24'h00_0001;
      end
      if (accept) begin
        totCnt_reg <= cmdLimit(newCmd);
        case (newCmd)
          CMD_AMP, CMD_PHASE, CMD_SUPPLY: state_reg <= ST_ADC;
          CMD_MODCAL, CMD_ANTCAL, CMD_CSCAL,
          CMD_CAPMEAS: state_reg <= ST_CAL;
          CMD_REGADJ: begin
            state_reg <= ST_SETTLE;
            stepCnt_reg <= 24'(REGSTEP_CYC);
          end
          CMD_SQUELCH: state_reg <= rxActive ? ST_IDLE : ST_SQUELCH;
          default: state_reg <= ST_IDLE;
        endcase
      end else if (finish) begin
        state_reg <= ST_IDLE;
      end else if (state_reg == ST_SETTLE && stepCnt_reg == 0) begin
        stepCnt_reg <= 24'(REGSTEP_CYC);
      end else if (state_reg == ST_SQUELCH &&
                   (squelchDone || totCnt_reg == 0)) begin
        state_reg <= ST_IDLE;
      end
    end
  end

  // Analog steering, held for the length of the command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      txEnable <= 1'b0;
      rxEnable <= 1'b0;
      ampDetEnable <= 1'b0;
      phaseDetEnable <= 1'b0;
      adcRelative <= 1'b0;
      adcMux <= MUX_AMP;
      supplyProbeSel <= 2'h0;
    end else if (clkEn) begin
      if (accept && isMeasure(newCmd)) begin
        txEnable <= newCmd == CMD_AMP || newCmd == CMD_PHASE ||
                    newCmd == CMD_REGADJ || newCmd == CMD_MODCAL ||
                    newCmd == CMD_ANTCAL;
        rxEnable <= newCmd == CMD_REGADJ;
        ampDetEnable <= newCmd == CMD_AMP;
        phaseDetEnable <= newCmd == CMD_PHASE;
        adcRelative <= newCmd == CMD_PHASE;
        adcMux <= newCmd == CMD_PHASE ? MUX_PHASE :
                  newCmd == CMD_SUPPLY ? MUX_SUPPLY : MUX_AMP;
        supplyProbeSel <= ctrl_reg[PROBE_LSB +: 2];
      end else if (finish) begin
        txEnable <= 1'b0;
        rxEnable <= 1'b0;
        ampDetEnable <= 1'b0;
        phaseDetEnable <= 1'b0;
        adcRelative <= 1'b0;
      end
    end
  end

  // Start strobes and completion pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      adcStart <= 1'b0;
      modCalStart <= 1'b0;
      antCalStart <= 1'b0;
      capCalStart <= 1'b0;
      capMeasStart <= 1'b0;
      squelchStart <= 1'b0;
      agcInit <= 1'b0;
      cmdDone <= 1'b0;
    end else if (clkEn) begin
      adcStart <= accept && (newCmd == CMD_AMP || newCmd == CMD_PHASE
                  || newCmd == CMD_SUPPLY);
      modCalStart <= accept && newCmd == CMD_MODCAL;
      antCalStart <= accept && newCmd == CMD_ANTCAL;
      capCalStart <= accept && newCmd == CMD_CSCAL;
      capMeasStart <= accept && newCmd == CMD_CAPMEAS;
      squelchStart <= accept && newCmd == CMD_SQUELCH
                      && !rxActive;
      agcInit <= accept && newCmd == CMD_GAINRST;
      cmdDone <= finish && isMeasure(cmd_reg);
    end
  end

  // Results; analog scaling lands the code as is, no rework here
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      adc_reg <= 8'h00;
      modDisp_reg <= 8'h00;
      tuningCapacitorPins <= 4'h0;
      gainReduction <= 8'h00;
      regCode <= REG_MAX;
    end else if (clkEn) begin
      if (state_reg == ST_ADC && adcDone) begin
        adc_reg <= adcData;
      end
      if (state_reg == ST_CAL && calDone && cmd_reg == CMD_MODCAL) begin
        modDisp_reg <= calResult;
      end
      if (state_reg == ST_CAL && calDone && cmd_reg == CMD_ANTCAL) begin
        tuningCapacitorPins <= calResult[3:0];
      end
      if (accept && newCmd == CMD_GAINRST) begin
        gainReduction <= rxCfg4_reg;
      end
      if (accept && newCmd == CMD_REGADJ) begin
        regCode <= REG_MAX;
      end else if (state_reg == ST_SETTLE && stepCnt_reg == 0 &&
                   !finish) begin
        regCode <= regCode - 4'h1;
      end
    end
  end

endmodule : mcs_sequencer

/* hw/mcs_pkg.sv */
package mcs_pkg;
  localparam int CLK_MHZ = 250;
  localparam int T_MEAS_NS = 25000;
  localparam int T_SQUELCH_NS = 500000;
  localparam int T_REGADJ_NS = 5000000;
  localparam int T_REGSTEP_NS = 300000;
  localparam int T_MODCAL_NS = 275000;
  localparam int T_ANTCAL_NS = 250000;
  localparam int T_CSCAL_NS = 3000000;
  localparam int T_CAPMEAS_NS = 250000;
  localparam int CYC_MEAS = T_MEAS_NS * CLK_MHZ / 1000;
  localparam int CYC_SQUELCH = T_SQUELCH_NS * CLK_MHZ / 1000;
  localparam int CYC_REGADJ = T_REGADJ_NS * CLK_MHZ / 1000;
  localparam int CYC_REGSTEP = T_REGSTEP_NS * CLK_MHZ / 1000;
  localparam int CYC_MODCAL = T_MODCAL_NS * CLK_MHZ / 1000;
  localparam int CYC_ANTCAL = T_ANTCAL_NS * CLK_MHZ / 1000;
  localparam int CYC_CSCAL = T_CSCAL_NS * CLK_MHZ / 1000;
  localparam int CYC_CAPMEAS = T_CAPMEAS_NS * CLK_MHZ / 1000;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ADC = 8'h0C;
  localparam logic [7:0] ADDR_RSSI = 8'h10;
  localparam logic [7:0] ADDR_REGV = 8'h14;
  localparam logic [7:0] ADDR_MODTGT = 8'h18;
  localparam logic [7:0] ADDR_MODDISP = 8'h1C;
  localparam logic [7:0] ADDR_RXCFG4 = 8'h20;
  localparam int EN_BIT = 7;
  localparam int EXTREG_BIT = 6;
  localparam int MCAL_LSB = 2;
  localparam int PROBE_LSB = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_CHAIN = 2;
  localparam int STAT_TRANSP = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODTGT_RST = 8'h00;
  localparam logic [7:0] RXCFG4_RST = 8'h00;
  localparam logic [3:0] REG_MAX = 4'hA;
  localparam logic [3:0] REG_MIN = 4'h0;
  localparam logic [1:0] MUX_AMP = 2'h0;
  localparam logic [1:0] MUX_PHASE = 2'h1;
  localparam logic [1:0] MUX_SUPPLY = 2'h2;
  typedef enum logic [3:0] {
    CMD_AMP = 4'h1,
    CMD_SQUELCH = 4'h2,
    CMD_GAINRST = 4'h3,
    CMD_REGADJ = 4'h4,
    CMD_MODCAL = 4'h5,
    CMD_ANTCAL = 4'h6,
    CMD_PHASE = 4'h7,
    CMD_RSSICLR = 4'h8,
    CMD_TRANSP = 4'h9,
    CMD_CSCAL = 4'hA,
    CMD_CAPMEAS = 4'hB,
    CMD_SUPPLY = 4'hC
  } mcs_cmd_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADC, ST_SETTLE, ST_CAL, ST_SQUELCH
  } mcs_state_type;
endpackage : mcs_pkg

/* dv/mcs_chk.sv */
`timescale 1ns/100ps
module mcs_chk import mcs_pkg::*; #(
  parameter int MEAS_CYC = CYC_MEAS
) (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic railMarginOk, // Margin met
  input wire logic slaveSelPin, // Slave select
  input wire logic txEnable, // Tx on
  input wire logic rxEnable, // Rx on
  input wire logic ampDetEnable, // Amplitude detector
  input wire logic phaseDetEnable, // Phase detector
  input wire logic adcRelative, // Relative ADC
  input wire logic [1:0] adcMux, // ADC source
  input wire logic adcStart, // Conversion start
  input wire logic [3:0] regCode, // Regulator step
  input wire logic squelchStart, // Squelch start
  input wire logic modCalStart, // Depth cal start
  input wire logic antCalStart, // Antenna cal start
  input wire logic capCalStart, // Capsense cal start
  input wire logic capMeasStart, // Cap meas start
  input wire logic agcInit, // Gain reset pulse
  input wire logic transparentMode, // Transparent
  input wire logic chainAllowed, // Chaining
  input wire logic cmdDone // Completion
);
  // Margin covers start pulse, answer capture and done register
  localparam int MEAS_LIM = MEAS_CYC + 4;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence step_s;
    rxEnable && $past(rxEnable) && $changed(regCode);
  endsequence
  sequence hold_s;
    $stable(regCode) [*8];
  endsequence
  amp_path_a: assert property (adcStart && adcMux == MUX_AMP |->
    txEnable && ampDetEnable && !adcRelative) else $error("amp path off");
  phase_path_a: assert property (adcStart && adcMux == MUX_PHASE |->
    txEnable && phaseDetEnable && adcRelative) else $error("phase path off");
  meas_time_a: assert property (adcStart |-> ##[1:MEAS_LIM] cmdDone)
    else $error("measurement too slow");
  regadj_top_a: assert property ($rose(rxEnable) |->
    regCode == REG_MAX && txEnable) else $error("regulator not at top");
  reg_step_a: assert property (step_s |->
    regCode == $past(regCode) - 4'h1) else $error("regulator step wrong");
  step_hold_a: assert property (step_s |=> hold_s)
    else $error("regulator steps too close");
  margin_stop_a: assert property ($past(rxEnable) && $past(railMarginOk)
    |-> regCode >= $past(regCode)) else $error("step despite margin");
  chain_off_a: assert property (adcStart || squelchStart || modCalStart ||
    antCalStart || capCalStart || capMeasStart |-> !chainAllowed)
    else $error("chaining on measurement");
  chain_on_a: assert property (agcInit |-> chainAllowed && !cmdDone)
    else $error("gain reset chaining wrong");
  done_pulse_a: assert property (cmdDone |=> !cmdDone)
    else $error("completion not a pulse");
  transp_leave_a: assert property ($fell(slaveSelPin) |->
    ##[1:5] !transparentMode) else $error("transparent mode kept");
endmodule : mcs_chk

/* dv/mcs_analog_model.sv */
`timescale 1ns/100ps
module mcs_analog_model (
  input wire logic ref_clk, // Clock
  input wire logic slow, // Late answers
  input wire logic [7:0] code, // Result handed back
  input wire logic adcStart, // Conversion start
  input wire logic calStart, // Any calibration start
  input wire logic squelchStart, // Squelch start
  output logic adcDone, // Conversion done
  output logic [7:0] adcData, // Conversion code
  output logic calDone, // Calibration done
  output logic [7:0] calResult, // Calibration outcome
  output logic squelchDone // Squelch done
);
  int cnt = 0;
  logic [1:0] job = 2'h0;
  logic fire;
  assign fire = (cnt == 1);
  assign adcDone = fire && job == 2'h1;
  assign calDone = fire && job == 2'h2;
  assign squelchDone = fire && job == 2'h3;
  // Outside the done cycle the data lines show garbage, not a held value
  assign adcData = adcDone ? code : ~code;
  assign calResult = calDone ? code : ~code;
  always @(posedge ref_clk) begin
    if (adcStart || calStart || squelchStart) begin
      cnt <= slow ? 12 : 2;
      job <= adcStart ? 2'h1 : (calStart ? 2'h2 : 2'h3);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : mcs_analog_model

/* dv/tb.sv */
`timescale 1ns/100ps
module tb import mcs_pkg::*;;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, code = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic xtalStable = 0, txRunning = 0, rxRunning = 0, rxActive = 0;
  logic slaveSelPin = 0, railMarginOk = 0, slow = 0, clkEn = 1;
  logic [3:0] rssiIn = 4'h0, regCode, tuningCapacitorPins;
  logic pready, pslverr, adcDone, calDone, squelchDone, txEnable, rxEnable;
  logic ampDetEnable, phaseDetEnable, adcRelative, adcStart, modCalStart;
  logic antCalStart, capCalStart, capMeasStart, squelchStart, agcInit;
  logic rssiGate, transparentMode, chainAllowed, cmdDone;
  logic [7:0] adcData, calResult, modTarget, gainReduction;
  logic [1:0] adcMux, supplyProbeSel, probeSeen;
  int n_errors = 0, comparisons = 0, nPulse = 0;
  logic [7:0] codes [7] = '{8'hE6, 8'h1F, 8'h80, 8'h3C, 8'h11, 8'h22, 8'h33};
  mcs_cmd_type cmds [7] = '{CMD_AMP, CMD_PHASE, CMD_SUPPLY, CMD_MODCAL,
    CMD_ANTCAL, CMD_CSCAL, CMD_CAPMEAS};
  // Other limits keep their defaults: the partner answers long before them
  mcs_sequencer #(.MEAS_CYC(20), .REGADJ_CYC(200), .REGSTEP_CYC(10)) dut (
    .ref_clk, .sys_rst, .clkEn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .xtalStable, .txRunning, .rxRunning, .rxActive, .slaveSelPin,
    .railMarginOk, .adcDone, .adcData, .calDone, .calResult, .squelchDone,
    .rssiIn, .txEnable, .rxEnable, .ampDetEnable, .phaseDetEnable,
    .adcRelative, .adcMux, .supplyProbeSel, .adcStart, .regCode,
    .modCalStart, .modTarget, .antCalStart, .tuningCapacitorPins,
    .capCalStart, .capMeasStart, .squelchStart, .agcInit, .gainReduction,
    .rssiGate, .transparentMode, .chainAllowed, .cmdDone);
  mcs_analog_model ana (.ref_clk, .slow, .code, .adcStart,
    .calStart(modCalStart | antCalStart | capCalStart | capMeasStart),
    .squelchStart, .adcDone, .adcData, .calDone, .calResult, .squelchDone);
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (adcStart | modCalStart | antCalStart | capCalStart | capMeasStart |
        squelchStart | agcInit | cmdDone) nPulse <= nPulse + 1;
    if (adcStart && adcMux == MUX_SUPPLY) probeSeen <= supplyProbeSel;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One idle cycle after each transfer keeps psel from being set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  task automatic waitDone(input int lim);
    logic got;
    got = 1'b0;
    repeat (lim) begin
      @(posedge ref_clk);
      if (cmdDone === 1'b1) got = 1'b1;
    end
    chk("completion", 32'h1, {31'h0, got});
  endtask : waitDone
  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    int n0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(ADDR_CTRL, {24'h0, CTRL_RST}, "ctrl");
    rd(ADDR_REGV, {28'h0, REG_MAX}, "regv");
    rd(8'h40, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_CTRL, 32'h80);
    for (int i = 0; i < 2; i++) begin
      n0 = nPulse;
      apb(1'b1, ADDR_CMD, {28'h0, CMD_AMP});
      repeat (30) @(posedge ref_clk);
      chk("refused", n0, nPulse);
      apb(1'b1, ADDR_CTRL, 32'h00);
      xtalStable <= 1'b1;
    end
    rd(ADDR_ADC, 32'h0, "adc kept");
    apb(1'b1, ADDR_CTRL, 32'h83);
    foreach (cmds[i]) begin
      code <= codes[i];
      slow <= i[0];
      apb(1'b1, ADDR_CMD, {28'h0, cmds[i]});
      waitDone(i < 3 ? 24 : 54);
      if (i < 3) rd(ADDR_ADC, {24'h0, codes[i]}, "adc");
      rd(ADDR_STAT, 32'h2, "stat");
      apb(1'b1, ADDR_STAT, 32'h2);
    end
    chk("probe", 32'h3, {30'h0, probeSeen});
    rd(ADDR_MODDISP, 32'h3C, "depth display");
    chk("tuning caps", 32'h1, {28'h0, tuningCapacitorPins});
    apb(1'b1, ADDR_MODTGT, 32'h4D);
    chk("depth target", 32'h4D, {24'h0, modTarget});
    for (int i = 0; i < 2; i++) begin
      railMarginOk <= i[0];
      apb(1'b1, ADDR_CMD, {28'h0, CMD_REGADJ});
      waitDone(204);
      rd(ADDR_REGV, {28'h0, i ? REG_MAX : REG_MIN}, "regv");
    end
    apb(1'b1, ADDR_CTRL, 32'hFF);
    n0 = nPulse;
    apb(1'b1, ADDR_CMD, {28'h0, CMD_REGADJ});
    apb(1'b1, ADDR_CMD, {28'h0, CMD_CSCAL});
    apb(1'b1, ADDR_CMD, {28'h0, CMD_SQUELCH});
    repeat (60) @(posedge ref_clk);
    chk("refused", n0, nPulse);
    apb(1'b1, ADDR_CTRL, 32'h80);
    apb(1'b1, ADDR_RXCFG4, 32'h5A);
    txRunning <= 1'b1;
    rxRunning <= 1'b1;
    n0 = nPulse;
    apb(1'b1, ADDR_CMD, {28'h0, CMD_SQUELCH});
    apb(1'b1, ADDR_CMD, {28'h0, CMD_GAINRST});
    repeat (60) @(posedge ref_clk);
    chk("pulses", n0 + 2, nPulse);
    chk("gain", 32'h5A, {24'h0, gainReduction});
    rssiIn <= 4'h9;
    rxActive <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rssiIn <= 4'h3;
    repeat (4) @(posedge ref_clk);
    rd(ADDR_RSSI, 32'h9, "rssi peak");
    chk("gate", 32'h1, {31'h0, rssiGate});
    apb(1'b1, ADDR_CMD, {28'h0, CMD_RSSICLR});
    repeat (4) @(posedge ref_clk);
    rd(ADDR_RSSI, 32'h3, "rssi restart");
    // A larger level while frozen must not reach the peak register
    clkEn <= 1'b0;
    rssiIn <= 4'hF;
    repeat (4) @(posedge ref_clk);
    chk("pready frozen", 32'h0, {31'h0, pready});
    clkEn <= 1'b1;
    rssiIn <= 4'h3;
    rd(ADDR_RSSI, 32'h3, "rssi frozen");
    chk("chain", 32'h1, {31'h0, chainAllowed});
    apb(1'b1, ADDR_CMD, {28'h0, CMD_TRANSP});
    chk("transparent early", 32'h0, {31'h0, transparentMode});
    slaveSelPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("transparent", 32'h1, {31'h0, transparentMode});
    slaveSelPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("transparent left", 32'h0, {31'h0, transparentMode});
    report_and_stop;
  end
endmodule : tb
bind mcs_sequencer mcs_chk #(.MEAS_CYC(MEAS_CYC)) chk_u (.ref_clk, .sys_rst,
  .railMarginOk, .slaveSelPin, .txEnable, .rxEnable, .ampDetEnable,
  .phaseDetEnable, .adcRelative, .adcMux, .adcStart, .regCode, .squelchStart,
  .modCalStart, .antCalStart, .capCalStart, .capMeasStart, .agcInit,
  .transparentMode, .chainAllowed, .cmdDone);
